// ==== hdl/tst_fisu_thin.sv ====
// Fill-in signal unit thinning for the common channel
`timescale 1ns/1ps

module tst_fisu_thin (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic enable_i,
  input wire logic [4:0] ss7_slot_i,
  input wire logic [3:0] rate_i,
  input wire logic su_valid_i,
  input wire tst_pkg::tst_su_t su_i,
  output logic su_valid_o,
  output tst_pkg::tst_su_t su_o,
  output logic fisu_drop_o
);
  import tst_pkg::*;

  logic [3:0] rate;
  logic [3:0] acc_reg;
  logic [4:0] acc_sum;
  logic is_fisu;
  logic drop;

  // Out-of-range settings clamp to ninety percent
  assign rate = (rate_i > RATE_MAX) ? RATE_MAX : rate_i;

  // Only units on the signaling timeslot are candidates
  assign is_fisu = enable_i && su_valid_i && (su_i.slot == ss7_slot_i)
                   && (su_i.li == FISU_LI);

  // Bresenham spread: N drops in every ten fill-in units
  // Sum needs five bits: nine plus nine would wrap in four
  assign acc_sum = {1'b0, acc_reg} + {1'b0, rate};
  assign drop = is_fisu && (acc_sum >= {1'b0, RATE_STEPS});

  // Accumulator moves on fill-in units only
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || !enable_i) begin
      acc_reg <= ACC_RST;
    end else if (is_fisu) begin
      acc_reg <= drop ? 4'(acc_sum - {1'b0, RATE_STEPS})
                      : acc_sum[3:0];
    end
  end

  // Message and status units always pass
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      su_valid_o <= 1'b0;
      su_o <= '0;
      fisu_drop_o <= 1'b0;
    end else begin
      su_valid_o <= su_valid_i && !drop;
      su_o <= su_i;
      fisu_drop_o <= drop;
    end
  end

endmodule // tst_fisu_thin

// ==== hdl/tst_translator.sv ====
// Trunk signaling translator: CAS profile mapping and FISU thinning
`timescale 1ns/1ps

module tst_translator (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Mode: high for CAS, low for CCS
  input wire logic cas_mode_i,
  // Profile write port
  input wire logic cfg_we_i,
  input wire logic [2:0] cfg_profile_i,
  input wire tst_pkg::tst_profile_t cfg_data_i,
  output logic cfg_err_o,
  // Profile selection and readback
  input wire logic [2:0] act_profile_i,
  output logic [2:0] act_profile_o,
  output tst_pkg::tst_profile_t act_data_o,
  // Channel state
  input wire logic chan_idle_i,
  input wire logic chan_oos_i,
  input wire logic bundle_down_i,
  // Timeslot stream from the remote side
  input wire logic slot_valid_i,
  input wire tst_pkg::tst_slot_t slot_i,
  // Timeslot stream toward the PBX
  output logic slot_valid_o,
  output tst_pkg::tst_slot_t slot_o,
  // Common channel configuration and stream
  input wire logic [4:0] ss7_slot_i,
  input wire logic [3:0] supp_rate_i,
  input wire logic su_valid_i,
  input wire tst_pkg::tst_su_t su_i,
  output logic su_valid_o,
  output tst_pkg::tst_su_t su_o,
  output logic fisu_drop_o
);
  import tst_pkg::*;

  // Profile store and the translation path share one clock.
  // Every control input comes from logic on that clock, so
  // nothing here needs a synchroniser; a pin-driven caller
  // must register its inputs first.
  tst_profile_t prof_reg [NUM_PROFILES];
  logic [2:0] act_reg;
  logic cfg_ok;
  logic act_ok;
  tst_profile_t act_prof;
  logic [3:0] mapped;
  logic [3:0] abcd_next;
  logic [7:0] data_next;

  // Profile numbers outside one to five are refused
  function automatic logic prof_num_ok(input logic [2:0] num);
    prof_num_ok = (num >= PROFILE_FIRST) && (num <= PROFILE_LAST);
  endfunction

  // One outgoing bit from its selector and the received bits.
  // Codes ten to fifteen are not legal, yet the write port stores them; they
  // fall to zero so a corrupt entry sends a quiet line state.
  // One outgoing bit from its selector and the received bits
  function automatic logic map_bit(input logic [3:0] sel,
                                   input logic [3:0] rx);
    logic r;
    r = 1'b0;
    unique case (sel)
      SRC_ZERO: r = 1'b0;
      SRC_ONE: r = 1'b1;
      SRC_A: r = rx[POS_A];
      SRC_NOT_A: r = ~rx[POS_A];
      SRC_B: r = rx[POS_B];
      SRC_NOT_B: r = ~rx[POS_B];
      SRC_C: r = rx[POS_C];
      SRC_NOT_C: r = ~rx[POS_C];
      SRC_D: r = rx[POS_D];
      SRC_NOT_D: r = ~rx[POS_D];
      default: r = 1'b0;
    endcase
    map_bit = r;
  endfunction

  assign cfg_ok = prof_num_ok(cfg_profile_i);
  assign act_ok = prof_num_ok(act_profile_i);

  // Profile store, one register per entry.
  // Illegal numbers leave every entry alone; a write lands
  // in the cycle after it is taken.
  for (genvar e = 0; e < NUM_PROFILES; e++) begin : g_prof
    logic hit;
    assign hit = cfg_we_i && cfg_ok
                 && (cfg_profile_i == 3'(e + 1));
    always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
        prof_reg[e] <= '{src: SRC_RST, idle: IDLE_RST, oos: OOS_RST};
      end else if (hit) begin
        prof_reg[e] <= cfg_data_i;
      end
    end
  end

  // Refused writes show for one cycle.
  // A caller that misses the pulse cannot learn of it later.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cfg_err_o <= 1'b0;
    end else begin
      cfg_err_o <= cfg_we_i && !cfg_ok;
    end
  end

  // Active selection holds its last legal number.
  // Ignoring bad numbers keeps the line state steady instead
  // of dropping to some default profile mid-call.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      act_reg <= PROFILE_RST;
    end else if (act_ok) begin
      act_reg <= act_profile_i;
    end
  end

  // A single entry feeds the translation
  assign act_prof = prof_reg[3'(act_reg - PROFILE_FIRST)];

  // Readback of the selected entry, registered.
  // Same one-cycle delay as the translation path.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      act_profile_o <= PROFILE_RST;
      act_data_o <= '{src: SRC_RST, idle: IDLE_RST, oos: OOS_RST};
    end else begin
      act_profile_o <= act_reg;
      act_data_o <= act_prof;
    end
  end

  // Per-bit source mapping.
  // Index 3 of the selector array feeds outgoing A.
  for (genvar g = 0; g < NUM_SIG_BITS; g++) begin : g_map
    assign mapped[g] = map_bit(act_prof.src[g], slot_i.abcd);
  end

  // Channel state is sampled in the same cycle as the timeslot,
  // so a state change takes effect on the very next slot.
  // In CCS mode the signaling bits pass untouched.
  // Priority: lost bundle, then out of service, then idle, then map.
  // Bundle loss outranks the per-channel state so the PBX can fail over.
  always_comb begin
    abcd_next = slot_i.abcd;
    data_next = slot_i.data;
    if (cas_mode_i) begin
      if (bundle_down_i) begin
        abcd_next = act_prof.oos;
      end else if (chan_oos_i) begin
        abcd_next = act_prof.oos;
      end else if (chan_idle_i) begin
        abcd_next = act_prof.idle;
      end else begin
        abcd_next = mapped;
      end
    end else if (bundle_down_i) begin
      data_next = CCS_DOWN_FILL;
    end
  end

  // Output timeslot register, one cycle of latency.
  // No ready signal: the PBX side must take every slot, and
  // the slot number rides along so gaps stay visible.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      slot_valid_o <= 1'b0;
      slot_o <= '0;
    end else begin
      slot_valid_o <= slot_valid_i;
      slot_o <= '{num: slot_i.num, abcd: abcd_next, data: data_next};
    end
  end

  // Thinning runs only on the common channel.
  // Holding it disabled in CAS mode also clears its spread
  // state, so a mode change starts a fresh ten-unit window.
  tst_fisu_thin u_thin (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .enable_i(!cas_mode_i),
    .ss7_slot_i(ss7_slot_i),
    .rate_i(supp_rate_i),
    .su_valid_i(su_valid_i),
    .su_i(su_i),
    .su_valid_o(su_valid_o),
    .su_o(su_o),
    .fisu_drop_o(fisu_drop_o)
  );

endmodule // tst_translator

// ==== include/tst_pkg.sv ====
// Shared types and constants for the trunk signaling translator
package tst_pkg;

  // Profile store
  localparam int NUM_PROFILES = 5;
  localparam logic [2:0] PROFILE_FIRST = 3'h1;
  localparam logic [2:0] PROFILE_LAST = 3'h5;
  localparam logic [2:0] PROFILE_RST = 3'h1;

  // Signaling bit count and field positions (A is the top bit)
  localparam int NUM_SIG_BITS = 4;
  localparam int POS_A = 3;
  localparam int POS_B = 2;
  localparam int POS_C = 1;
  localparam int POS_D = 0;

  // Source selectors for one outgoing bit, ten legal codes
  typedef enum logic [3:0] {
    SRC_ZERO  = 4'h0,
    SRC_ONE   = 4'h1,
    SRC_A     = 4'h2,
    SRC_NOT_A = 4'h3,
    SRC_B     = 4'h4,
    SRC_NOT_B = 4'h5,
    SRC_C     = 4'h6,
    SRC_NOT_C = 4'h7,
    SRC_D     = 4'h8,
    SRC_NOT_D = 4'h9
  } tst_src_t;

  // One translation profile
  typedef struct packed {
    logic [3:0][3:0] src;  // Index 3 drives outgoing A
    logic [3:0] idle;
    logic [3:0] oos;
  } tst_profile_t;

  // Values after reset: straight copy, idle and oos code 1000
  localparam logic [15:0] SRC_RST = 16'h2468;
  localparam logic [3:0] IDLE_RST = 4'h8;
  localparam logic [3:0] OOS_RST = 4'h8;

  // One timeslot of the voice stream
  typedef struct packed {
    logic [4:0] num;
    logic [3:0] abcd;
    logic [7:0] data;
  } tst_slot_t;

  // Fill toward the PBX on a lost bundle in CCS mode
  localparam logic [7:0] CCS_DOWN_FILL = 8'hFF;

  // One signal unit header on the common channel
  typedef struct packed {
    logic [4:0] slot;
    logic [5:0] li;
  } tst_su_t;

  // Length indicator of a fill-in unit
  localparam logic [5:0] FISU_LI = 6'h00;

  // Suppression: tenths, 0 to 9
  localparam logic [3:0] RATE_MAX = 4'h9;
  localparam logic [3:0] RATE_STEPS = 4'hA;
  localparam logic [3:0] RATE_RST = 4'h0;
  localparam logic [3:0] ACC_RST = 4'h0;
  localparam logic [4:0] SS7_SLOT_RST = 5'h10;

endpackage : tst_pkg

// ==== sim/tb.sv ====
// Self-checking bench for the signaling translator
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb;
  import tst_pkg::*;
  logic sys_clk_i = 0, sys_rst_i = 1, cas_mode_i = 1, cfg_we_i = 0;
  logic [2:0] cfg_profile_i = 3'h1, act_profile_i = 3'h1, act_profile_o;
  tst_profile_t cfg_data_i = '0, act_data_o;
  logic chan_idle_i = 0, chan_oos_i = 0, bundle_down_i = 0;
  logic slot_valid_i = 0, slot_valid_o, su_valid_i = 0, su_valid_o;
  tst_slot_t slot_i = '0, slot_o;
  logic [4:0] ss7_slot_i = 5'h10;
  logic [3:0] supp_rate_i = 4'h0, rx_abcd;
  tst_su_t su_i = '0, su_o;
  logic cfg_err_o, fisu_drop_o;
  int err_count = 0, checks = 0;
  tst_translator u_dut (.*);
  tst_pbx_model u_pbx (.sys_clk_i(sys_clk_i), .slot_valid_i(slot_valid_o),
    .slot_i(slot_o), .rx_abcd_o(rx_abcd));
  always #10 sys_clk_i = ~sys_clk_i;
  task automatic close_out();
    if (err_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [2:0] p, input tst_profile_t d);
    @(negedge sys_clk_i) {cfg_we_i, cfg_profile_i, cfg_data_i} = {1'b1, p, d};
    @(negedge sys_clk_i) cfg_we_i = 0;
  endtask
  // PBX sees the bits two edges after the drive
  task automatic slot(input logic [3:0] abcd, input logic [3:0] exp);
    @(negedge sys_clk_i) {slot_valid_i, slot_i} = {1'b1, 5'h2, abcd, 8'h5A};
    @(negedge sys_clk_i) slot_valid_i = 0;
    @(negedge sys_clk_i) `CHK(rx_abcd, exp)
  endtask
  // Outgoing A walks all ten sources over two bit patterns
  task automatic t_map();
    logic [3:0] p;
    for (int k = 0; k < 10; k++) begin
      wr(3'h3, {4'(k), 4'h4, 4'h6, 4'h8, 4'h5, 4'hA});
      for (int j = 0; j < 2; j++) begin
        p = j ? 4'b0110 : 4'b1010;
        slot(p, {k < 2 ? k[0] : p[4 - k / 2] ^ k[0], p[2:0]});
      end
    end
  endtask
  // Ten FISUs, then a foreign-slot FISU and an MSU
  task automatic t_thin(input logic [3:0] r);
    int n;
    int v;
    n = 0;
    v = 0;
    supp_rate_i = r;
    for (int i = 0; i < 13; i++) begin
      @(negedge sys_clk_i) n += fisu_drop_o;
      v += su_valid_o;
      su_valid_i = i < 12;
      su_i = {i == 10 ? 5'h3 : ss7_slot_i, i == 11 ? 6'h3 : 6'h0};
    end
    @(negedge sys_clk_i) `CHK(n, int'(r))
    `CHK(v, 12 - int'(r))
    `CHK(su_o, {ss7_slot_i, 6'h0})
  endtask
  initial begin
    repeat (12) @(negedge sys_clk_i);
    `CHK(act_profile_o, 3'h1)
    `CHK(act_data_o, {16'h2468, 4'h8, 4'h8})
    sys_rst_i = 0;
    act_profile_i = 3'h3;
    t_map();
    wr(3'h0, '0);
    `CHK(cfg_err_o, 1'b1)
    wr(3'h6, '0);
    `CHK(cfg_err_o, 1'b1)
    wr(3'h5, '0);
    `CHK(cfg_err_o, 1'b0)
    wr(3'h3, {16'h2468, 4'h5, 4'hA});
    chan_idle_i = 1;
    slot(4'hF, 4'h5);
    chan_oos_i = 1;
    slot(4'hF, 4'hA);
    {chan_idle_i, chan_oos_i, bundle_down_i} = 3'b001;
    slot(4'hF, 4'hA);
    cas_mode_i = 0;
    slot(4'h6, 4'h6);
    bundle_down_i = 0;
    t_thin(4'h0);
    t_thin(4'h5);
    t_thin(4'h9);
    close_out();
  end
  initial begin
    #100us;
    err_count++;
    close_out();
  end
endmodule // tb

// ==== sim/tst_pbx_model.sv ====
// Local PBX model latching the signaling bits it receives
`timescale 1ns/1ps
module tst_pbx_model (
  input wire logic sys_clk_i,
  input wire logic slot_valid_i,
  input wire tst_pkg::tst_slot_t slot_i,
  output logic [3:0] rx_abcd_o
);
  import tst_pkg::*;
  initial rx_abcd_o = 4'h0;
  // A PBX holds line state until new bits arrive
  always @(posedge sys_clk_i)
    if (slot_valid_i) rx_abcd_o <= slot_i.abcd;
endmodule // tst_pbx_model

// ==== sim/tst_translator_props.sv ====
// Concurrent checks on the translator top ports
`timescale 1ns/1ps
module tst_translator_props (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic cas_mode_i,
  input wire logic cfg_we_i,
  input wire logic [2:0] cfg_profile_i,
  input wire logic cfg_err_o,
  input wire logic [2:0] act_profile_o,
  input wire tst_pkg::tst_profile_t act_data_o,
  input wire logic bundle_down_i,
  input wire logic slot_valid_i,
  input wire logic slot_valid_o,
  input wire tst_pkg::tst_slot_t slot_o,
  input wire logic [4:0] ss7_slot_i,
  input wire logic [3:0] supp_rate_i,
  input wire logic su_valid_i,
  input wire tst_pkg::tst_su_t su_i,
  input wire logic su_valid_o,
  input wire logic fisu_drop_o
);
  import tst_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Writes outside 1..5 must be flagged
  property p_bad; cfg_we_i && !(cfg_profile_i inside {[1:5]}) |=> cfg_err_o;
  endproperty
  a_bad: assert property (p_bad) else $error("bad write");
  property p_act; act_profile_o inside {[1:5]}; endproperty
  a_act: assert property (p_act) else $error("active out");
  property p_lat; 1'b1 |=> slot_valid_o == $past(slot_valid_i); endproperty
  a_lat: assert property (p_lat) else $error("slot latency");
  // Oos code is read from the live profile, so both must agree
  property p_down;
    cas_mode_i && slot_valid_i && bundle_down_i |=> slot_o.abcd == act_data_o.oos;
  endproperty
  a_down: assert property (p_down) else $error("down code");
  property p_fill;
    !cas_mode_i && slot_valid_i && bundle_down_i |=> slot_o.data == 8'hFF;
  endproperty
  a_fill: assert property (p_fill) else $error("down fill");
  property p_zero; supp_rate_i == 4'h0 |=> !fisu_drop_o; endproperty
  a_zero: assert property (p_zero) else $error("zero rate");
  property p_msu; su_valid_i && su_i.li != 6'h0 |=> su_valid_o; endproperty
  a_msu: assert property (p_msu) else $error("msu lost");
  property p_slot; su_valid_i && su_i.slot != ss7_slot_i |=> su_valid_o;
  endproperty
  a_slot: assert property (p_slot) else $error("slot lost");
  property p_cas; cas_mode_i |=> !fisu_drop_o; endproperty
  a_cas: assert property (p_cas) else $error("cas drop");
  c_drop: cover property (fisu_drop_o);
  c_err: cover property (cfg_err_o);
  c_down: cover property (cas_mode_i && bundle_down_i && slot_valid_i);
endmodule // tst_translator_props
bind tst_translator tst_translator_props u_props (.*);
